// ---- gsfs_pkg.sv ----
// Purpose: Shared constants and types of the global shutter frame scan.
// Assumes: The block clock runs at 200 MHz.
// Notes:   Times are kept in nanoseconds and turned into cycle counts here.

package gsfs_pkg;

	// ****************************************************************
	// Array geometry and port layout.
	// ****************************************************************
	localparam int ROWS_DEF  = 256;
	localparam int COLS_DEF  = 320;
	localparam int PORTS_DEF = 4;

	// ****************************************************************
	// Timing figures and their cycle counts.
	// ****************************************************************
	localparam int CLK_MHZ        = 200;
	localparam int PIX_CLKS_DEF   = 4;
	localparam int ROW_GAP_NS     = 1220;
	// Gap is a least time, so the count rounds up.
	localparam int ROW_GAP_CYC    = (ROW_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int MIN_INTEG_NS   = 1;
	localparam int MAX_FPS        = 507;
	// Longest frame period that still meets the top frame rate.
	localparam int FRAME_MAX_NS   = 1000000000 / MAX_FPS;
	localparam int FRAME_MAX_CYC  = (FRAME_MAX_NS / 1000) * CLK_MHZ;
	// Row overhead: signal transfer, pixel reset, reset transfer.
	localparam int ROW_PREP_CYC   = 3;

	// ****************************************************************
	// Scan sequencer states, Gray coded along the path from IDLE through OUT to GAP.
	// ****************************************************************
	typedef enum logic [2:0] {
		GSFS_IDLE  = 3'h0,
		GSFS_INTEG = 3'h1,
		GSFS_HOLD  = 3'h3,
		GSFS_SIG   = 3'h2,
		GSFS_RST   = 3'h6,
		GSFS_OUT   = 3'h7,
		GSFS_GAP   = 3'h5,
		GSFS_DONE  = 3'h4
	} gsfs_state_t;

endpackage

// ---- gsfs_sync.sv ----
// Purpose: Brings the frame start pin into the block clock domain.
// Assumes: The pin is asynchronous to clk.
// Notes:   A change counts once the second and third stages agree.

`timescale 1ns/10ps

module gsfs_sync
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Pin side.
	input  wire logic pin_in,
	// Clock domain side.
	output logic      level_out
);

	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_d;

	// Shift the pin in and accept a level only when two stages agree.
	always_comb
	begin
		stage_d = {stage_q[1:0], pin_in};
		level_d = level_out;
		if (stage_q[1] == stage_q[2])
		begin
			level_d = stage_q[2];
		end
	end

	// Stages reset high, the idle level of the pin, so that no false
	// integration starts before the pin has really been seen low.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stage_q   <= 3'h7;
			level_out <= 1'b1;
		end
		else
		begin
			stage_q   <= stage_d;
			level_out <= level_d;
		end
	end

endmodule

// ---- gsfs_frame_scan.sv ----
// Purpose: Frame scan sequencer of a global shutter area sensor.
// Assumes: clk stands for the master clock; the start pulse is a pin.
// Notes:   Analog paths are not modelled; strobes mark each analog step.

`timescale 1ns/10ps

// Overview of operation
// - Pixels integrate while the frame start pulse stays low and no scan is running.
// - At the end of integration all pixels are sampled at one instant.
// - Rows are selected one at a time from the top row to the bottom row.
// - Each selected row first moves its held optical level out as signal.
// - The row is then reset and its reset level is moved out and held.
// - The column scan emits signal and reset samples of each pixel serially.
// - After a row is output the row select advances by exactly one.
// - After the last row a low start pulse releases all pixel resets at once.
// - The scan covers 320 columns by 256 rows, every pixel included.
// - Four ports and a 1 ns integration allow up to 507 frames a second.
// - Each pixel occupies four master clock periods on the video output.
// - Scan control starts once the start pulse rises and then runs to the last row whatever the pulse does.
// - An idle gap of 1.22 us separates the output of consecutive rows.
module gsfs_frame_scan
#(
	parameter int ROWS     = gsfs_pkg::ROWS_DEF,
	parameter int COLS     = gsfs_pkg::COLS_DEF,
	parameter int PORTS    = gsfs_pkg::PORTS_DEF,
	parameter int PIX_CLKS = gsfs_pkg::PIX_CLKS_DEF,
	parameter int GAP_CYC  = gsfs_pkg::ROW_GAP_CYC
)
(
	// Clock and reset.
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Frame start pin from the controller.
	input  wire logic                      frame_start_pulse,
	// Pixel array control.
	output logic                           pix_reset_all,
	output logic                           integrating,
	output logic                           global_hold,
	// Row scan.
	output logic [$clog2(ROWS)-1:0]        row_idx,
	output logic                           row_sel_valid,
	output logic                           sig_xfer,
	output logic                           row_pix_reset,
	output logic                           rst_xfer,
	// Column scan and video.
	output logic [$clog2(COLS/PORTS)-1:0]  col_idx,
	output logic                           video_valid,
	output logic                           video_is_reset,
	output logic                           frame_done
);

	localparam int RW  = $clog2(ROWS);
	localparam int CPP = COLS / PORTS;
	localparam int CW  = $clog2(CPP);
	localparam int PW  = $clog2(PIX_CLKS);
	localparam int GW  = $clog2(GAP_CYC + 1);
	localparam int ROW_CYC = gsfs_pkg::ROW_PREP_CYC + CPP * PIX_CLKS
		+ GAP_CYC;

	// ****************************************************************
	// Elaboration checks.
	// ****************************************************************
	// The column split and the two-half pixel slot need these shapes.
	if (COLS % PORTS != 0 || PIX_CLKS < 2 || PIX_CLKS % 2 != 0
		|| ROWS < 2 || CPP < 2 || GAP_CYC < 1)
	begin : g_bad_shape
		$error("gsfs_frame_scan: unsupported geometry or timing");
	end
	// A frame at the shortest integration must fit the top frame rate.
	if (ROWS * ROW_CYC + 4 > gsfs_pkg::FRAME_MAX_CYC)
	begin : g_too_slow
		$error("gsfs_frame_scan: frame too long for the top frame rate");
	end

	// ****************************************************************
	// Start pulse synchroniser.
	// ****************************************************************
	logic start_lvl;

	gsfs_sync u_sync
	(
		.clk       (clk),
		.rst       (rst),
		.pin_in    (frame_start_pulse),
		.level_out (start_lvl)
	);

	// ****************************************************************
	// Sequencer state.
	// ****************************************************************
	gsfs_pkg::gsfs_state_t state_q;
	gsfs_pkg::gsfs_state_t state_d;
	logic [RW-1:0]         row_q;
	logic [RW-1:0]         row_d;
	logic [CW-1:0]         col_q;
	logic [CW-1:0]         col_d;
	logic [PW-1:0]         ph_q;
	logic [PW-1:0]         ph_d;
	logic [GW-1:0]         gap_q;
	logic [GW-1:0]         gap_d;

	// Output registers.
	logic pix_reset_all_d;
	logic integrating_d;
	logic global_hold_d;
	logic row_sel_valid_d;
	logic sig_xfer_d;
	logic row_pix_reset_d;
	logic rst_xfer_d;
	logic video_valid_d;
	logic video_is_reset_d;
	logic frame_done_d;

	// Next state, counters and every output strobe.
	always_comb
	begin
		state_d          = state_q;
		row_d            = row_q;
		col_d            = col_q;
		ph_d             = ph_q;
		gap_d            = gap_q;
		pix_reset_all_d  = 1'b0;
		integrating_d    = 1'b0;
		global_hold_d    = 1'b0;
		row_sel_valid_d  = 1'b0;
		sig_xfer_d       = 1'b0;
		row_pix_reset_d  = 1'b0;
		rst_xfer_d       = 1'b0;
		video_valid_d    = 1'b0;
		video_is_reset_d = 1'b0;
		frame_done_d     = 1'b0;
		unique case (state_q)
			gsfs_pkg::GSFS_IDLE, gsfs_pkg::GSFS_DONE:
			begin
				// Pixels stay in reset until the pulse is low.
				pix_reset_all_d = 1'b1;
				if (!start_lvl)
				begin
					// Release every pixel reset together.
					state_d         = gsfs_pkg::GSFS_INTEG;
					pix_reset_all_d = 1'b0;
					integrating_d   = 1'b1;
				end
			end
			gsfs_pkg::GSFS_INTEG:
			begin
				integrating_d = 1'b1;
				if (start_lvl)
				begin
					// Rising pulse ends integration and starts the scan.
					state_d       = gsfs_pkg::GSFS_HOLD;
					integrating_d = 1'b0;
					global_hold_d = 1'b1;
				end
			end
			gsfs_pkg::GSFS_HOLD:
			begin
				// All pixels are held; begin at the top row.
				state_d         = gsfs_pkg::GSFS_SIG;
				row_d           = '0;
				row_sel_valid_d = 1'b1;
				sig_xfer_d      = 1'b1;
			end
			gsfs_pkg::GSFS_SIG:
			begin
				// Signal sample moved; now reset the row's pixels.
				state_d         = gsfs_pkg::GSFS_RST;
				row_sel_valid_d = 1'b1;
				row_pix_reset_d = 1'b1;
			end
			gsfs_pkg::GSFS_RST:
			begin
				// Third step moves the reset level into the hold.
				row_sel_valid_d = 1'b1;
				state_d         = gsfs_pkg::GSFS_OUT;
				rst_xfer_d      = 1'b1;
				col_d           = '0;
				ph_d            = '0;
				video_valid_d   = 1'b0;
			end
			gsfs_pkg::GSFS_OUT:
			begin
				row_sel_valid_d = 1'b1;
				video_valid_d   = 1'b1;
				ph_d            = PW'(ph_q + 1'b1);
				// Signal in the first half of the slot, reset in the second.
				video_is_reset_d = (ph_q >= PW'(PIX_CLKS / 2));
				if (ph_q == PW'(PIX_CLKS - 1))
				begin
					// Slot of four clocks done; step to the next column.
					ph_d  = '0;
					col_d = CW'(col_q + 1'b1);
					if (col_q == CW'(CPP - 1))
					begin
						col_d         = '0;
						if (row_q == RW'(ROWS - 1))
						begin
							// Last row read: frame complete.
							state_d         = gsfs_pkg::GSFS_DONE;
							row_sel_valid_d = 1'b0;
							frame_done_d    = 1'b1;
							pix_reset_all_d = 1'b1;
						end
						else
						begin
							state_d         = gsfs_pkg::GSFS_GAP;
							gap_d           = GW'(GAP_CYC - 1);
							row_sel_valid_d = 1'b0;
						end
					end
				end
			end
			gsfs_pkg::GSFS_GAP:
			begin
				gap_d = GW'(gap_q - 1'b1);
				if (gap_q == '0)
				begin
					// Advance exactly one row and repeat the row steps.
					state_d         = gsfs_pkg::GSFS_SIG;
					row_d           = RW'(row_q + 1'b1);
					row_sel_valid_d = 1'b1;
					sig_xfer_d      = 1'b1;
					gap_d           = '0;
				end
			end
		endcase
	end

	// Register state, counters and outputs.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q        <= gsfs_pkg::GSFS_IDLE;
			row_q          <= '0;
			col_q          <= '0;
			ph_q           <= '0;
			gap_q          <= '0;
			pix_reset_all  <= 1'b1;
			integrating    <= 1'b0;
			global_hold    <= 1'b0;
			row_sel_valid  <= 1'b0;
			sig_xfer       <= 1'b0;
			row_pix_reset  <= 1'b0;
			rst_xfer       <= 1'b0;
			video_valid    <= 1'b0;
			video_is_reset <= 1'b0;
			frame_done     <= 1'b0;
		end
		else
		begin
			state_q        <= state_d;
			row_q          <= row_d;
			col_q          <= col_d;
			ph_q           <= ph_d;
			gap_q          <= gap_d;
			pix_reset_all  <= pix_reset_all_d;
			integrating    <= integrating_d;
			global_hold    <= global_hold_d;
			row_sel_valid  <= row_sel_valid_d;
			sig_xfer       <= sig_xfer_d;
			row_pix_reset  <= row_pix_reset_d;
			rst_xfer       <= rst_xfer_d;
			video_valid    <= video_valid_d;
			video_is_reset <= video_is_reset_d;
			frame_done     <= frame_done_d;
		end
	end

	// Row index follows the next row; the column index trails its
	// counter by one cycle so it lines up with the registered video.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			row_idx <= '0;
			col_idx <= '0;
		end
		else
		begin
			row_idx <= row_d;
			col_idx <= col_q;
		end
	end

endmodule

// ---- gsfs_frame_scan_monitor.sv ----
// Purpose: Watches the frame scan ports for sequencing slips.
// Assumes: One clock; rst is asynchronous and active high.
// Notes:   Bound to every instance of the frame scan.

`timescale 1ns/10ps

module gsfs_frame_scan_monitor
#(
	parameter int ROWS  = 256,
	parameter int COLS  = 320,
	parameter int PORTS = 4
)
(
	// Clock and reset.
	input wire logic                   clk,
	input wire logic                   rst,
	// Pin and array control.
	input wire logic                   frame_start_pulse,
	input wire logic                   pix_reset_all,
	input wire logic                   integrating,
	input wire logic                   global_hold,
	// Row and column scan.
	input wire logic [$clog2(ROWS)-1:0] row_idx,
	input wire logic                   row_sel_valid,
	input wire logic                   sig_xfer,
	input wire logic                   row_pix_reset,
	input wire logic                   rst_xfer,
	input wire logic [$clog2(COLS/PORTS)-1:0] col_idx,
	input wire logic                   video_valid,
	input wire logic                   video_is_reset
);
	logic [$clog2(ROWS)-1:0] last_d;
	logic [$clog2(ROWS)-1:0] last_q;

	// Remembers the row whose reset level moved last.
	always_comb
	begin
		last_d = rst_xfer ? row_idx : last_q;
	end

	// Registers the remembered row.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			last_q <= '0;
		else
			last_q <= last_d;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_hold_once;
		global_hold |=> !global_hold && $past(integrating, 2);
	endproperty
	a_hold_once: assert property (p_hold_once)
		else $error("global hold width or cause wrong");
	property p_first_row;
		global_hold |=> sig_xfer && row_sel_valid && row_idx == 0;
	endproperty
	a_first_row: assert property (p_first_row)
		else $error("first row not selected after hold");
	property p_row_steps;
		sig_xfer |=> row_pix_reset ##1 rst_xfer;
	endproperty
	a_row_steps: assert property (p_row_steps)
		else $error("row reset steps out of order");
	property p_video_go;
		rst_xfer |=> video_valid && col_idx == 0;
	endproperty
	a_video_go: assert property (p_video_go)
		else $error("video did not follow reset transfer");
	property p_slot;
		$rose(video_valid) |-> video_valid[*4];
	endproperty
	a_slot: assert property (p_slot)
		else $error("pixel slot shorter than four clocks");
	property p_pair;
		$rose(video_valid) |-> !video_is_reset ##2 video_is_reset;
	endproperty
	a_pair: assert property (p_pair)
		else $error("signal and reset samples misplaced");
	property p_row_next;
		sig_xfer && row_idx != 0 |-> row_idx == last_q + 1'b1;
	endproperty
	a_row_next: assert property (p_row_next)
		else $error("row did not advance by one");
	property p_integ_on;
		$rose(integrating) |-> !frame_start_pulse && !pix_reset_all;
	endproperty
	a_integ_on: assert property (p_integ_on)
		else $error("integration began without a low pulse");
	property p_integ_off;
		$fell(integrating) |-> frame_start_pulse;
	endproperty
	a_integ_off: assert property (p_integ_off)
		else $error("integration ended with the pulse low");
endmodule

bind gsfs_frame_scan gsfs_frame_scan_monitor
	#(.ROWS(ROWS), .COLS(COLS), .PORTS(PORTS)) i_mon
	(.clk(clk), .rst(rst), .frame_start_pulse(frame_start_pulse),
	.pix_reset_all(pix_reset_all), .integrating(integrating),
	.global_hold(global_hold), .row_idx(row_idx),
	.row_sel_valid(row_sel_valid), .sig_xfer(sig_xfer),
	.row_pix_reset(row_pix_reset), .rst_xfer(rst_xfer),
	.col_idx(col_idx), .video_valid(video_valid),
	.video_is_reset(video_is_reset));

// ---- gsfs_ctrl_model.sv ----
// Purpose: Timing controller that drives the frame start pin.
// Assumes: Changes land on the falling clock edge.
// Notes:   The pin idles high, so no frame starts until asked.

`timescale 1ns/10ps

module gsfs_ctrl_model
(
	// Clock in, start pin out.
	input wire logic clk,
	output logic     frame_start_pulse
);
	initial frame_start_pulse = 1'b1;

	// One frame: low phase of lo clocks (at least 50), then high for hi clocks.
	task frame(input int lo, input int hi);
		@(negedge clk) frame_start_pulse = 1'b0;
		repeat (lo < 50 ? 50 : lo) @(negedge clk);
		frame_start_pulse = 1'b1;
		repeat (hi) @(negedge clk);
	endtask
endmodule

// ---- gsfs_frame_scan_tb.sv ----
// Purpose: Self-checking bench of the frame scan sequencer.
// Assumes: A shrunk array of 2 rows by 8 columns over 4 ports.
// Notes:   Counters tally every strobe seen at each falling edge.

`timescale 1ns/10ps

module gsfs_frame_scan_tb;
	localparam int R = 2;
	localparam int CP = 2;
	localparam int G = 2;
	logic clk = 0;
	logic rst = 1;
	logic fsp;
	logic pra, itg, gh, rsv, sx, rpr, rx, vv, vr, fd;
	logic [$clog2(R)-1:0] row_idx;
	logic [$clog2(CP)-1:0] col_idx;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int nh, ns, nv, nd, ni, bad, np, nx, last_v, gap_seen;

	always #2.5 clk = ~clk;

	gsfs_ctrl_model i_ctrl (.clk(clk), .frame_start_pulse(fsp));

	gsfs_frame_scan #(.ROWS(R), .COLS(8), .PORTS(4), .PIX_CLKS(4),
		.GAP_CYC(G)) i_dut
		(.clk(clk), .rst(rst), .frame_start_pulse(fsp),
		.pix_reset_all(pra), .integrating(itg), .global_hold(gh),
		.row_idx(row_idx), .row_sel_valid(rsv), .sig_xfer(sx),
		.row_pix_reset(rpr), .rst_xfer(rx), .col_idx(col_idx),
		.video_valid(vv), .video_is_reset(vr), .frame_done(fd));

	// Tallies strobes and checks row, column and sample order.
	always @(negedge clk)
	begin
		if (sx === 1'b1)
		begin
			if (ns == 1)
				gap_seen = cyc - last_v;
			bad += (row_idx !== ns[0]);
			ns++;
		end
		if (vv === 1'b1)
		begin
			bad += (col_idx !== nv / 4 % CP);
			bad += (vr !== (nv % 4 >= 2));
			nv++;
			last_v = cyc;
		end
		np += (rpr === 1'b1);
		nx += (rx === 1'b1);
		nh += (gh === 1'b1);
		nd += (fd === 1'b1);
		ni += (itg === 1'b1);
	end

	// Cuts a hung run short.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		checks++;
		if (seen !== ex)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %0h seen %0h", nm, ex, seen);
		end
	endtask

	task give_verdict();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Reset values: pixel resets on; integrating, hold, signal transfer, video and done quiet.
	task t_reset();
		chk("reset_all", pra, 1);
		chk("strobes", {itg, gh, sx, vv, fd}, 0);
	endtask

	// One whole frame with a low phase of lo clocks.
	task t_frame(input int lo);
		@(posedge clk);
		{nh, ns, nv, nd, ni, bad, np, nx, last_v, gap_seen} = 0;
		i_ctrl.frame(lo, 80);
		chk("holds", nh, 1);
		chk("rows", ns, R);
		chk("video", nv, R * CP * 4);
		chk("order", bad, 0);
		chk("row_resets", np, R);
		chk("reset_moves", nx, R);
		chk("row_gap", gap_seen, G);
		chk("done", nd, 1);
		chk("integ", ni >= lo - 1 && ni <= lo + 1, 1);
		chk("reset_after", pra, 1);
	endtask

	// Reset in mid scan, then a clean frame must follow.
	task t_mid_reset();
		i_ctrl.frame(50, 12);
		rst = 1;
		@(negedge clk);
		t_reset();
		rst = 0;
		t_frame(50);
	endtask

	initial
	begin
		repeat (16) @(negedge clk);
		t_reset();
		rst = 0;
		t_frame(50);
		t_frame(120);
		t_frame(50);
		t_mid_reset();
		give_verdict();
	end
endmodule
